// [rtl/adc_frame_pkg.sv]
// Purpose: shared constants and types of the serial frame and power control block
// Assumes: system clock of 200 MHz; serial clock supplied by the host
// Notes: edge numbers count serial clock falling edges from the frame fall
package adc_frame_pkg;
  // =====================================================================
  // clock and timing
  // =====================================================================
  localparam int CLK_PERIOD_NS = 5; // system clock period
  localparam int PWRUP_TIME_NS = 1000; // analog power-up time after wake
  // least time, so round up to whole cycles
  localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_CNT_W = $clog2(PWRUP_CYCLES + 1); // power-up counter width
  localparam int RELEASE_TO_HIZ_DELAY_NS = 35; // frame rise to three-state, longest
  // longest time, so round down
  localparam int RELEASE_TO_HIZ_CYCLES = RELEASE_TO_HIZ_DELAY_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_TRACK_INTERVAL_NS = 290; // host side acquisition minimum
  localparam int BUS_IDLE_GAP_NS = 60; // host side quiet minimum

  // =====================================================================
  // frame edge numbers
  // =====================================================================
  localparam int EDGE_CNT_W = 5; // edge counter width
  localparam logic [4:0] EDGE_DOWN_MIN = 5'h02; // power-down window opens
  localparam logic [4:0] EDGE_TRIAL = 5'h03; // first trial bit set up
  localparam logic [4:0] EDGE_MSB = 5'h04; // msb shifted out
  localparam logic [4:0] EDGE_STAY_UP = 5'h0a; // stay powered from here
  localparam logic [4:0] EDGE_TRACK = 5'h0d; // sampler back to track after this
  localparam logic [4:0] EDGE_LSB = 5'h0f; // result_lsb shifted out
  localparam logic [4:0] EDGE_LAST = 5'h10; // frame complete, output released
  localparam int RESULT_BITS = 12; // converter resolution
  localparam logic [11:0] CODE_RESET = 12'h000; // empty trial code
  localparam logic [11:0] CODE_MSB = 12'h800; // first trial code

  // =====================================================================
  // link flags crossing into the system clock domain
  // =====================================================================
  localparam int FLG_EDGE = 0; // any serial clock edge seen
  localparam int FLG_SEEN2 = 1; // second falling edge seen
  localparam int FLG_SEEN10 = 2; // tenth falling edge seen
  localparam int FLG_TRACK = 3; // sampler released after edge 13
  localparam int FLG_DONE = 4; // sixteenth falling edge seen
  localparam int FLG_W = 5; // number of flags
  localparam logic [4:0] FLAGS_CLEAR = 5'h00; // no flag set

  // power state of the analog section
  typedef enum logic [1:0] {PWR_NORMAL, PWR_DOWN, PWR_WAKING} power_state_type;
endpackage

// [rtl/level_sync.sv]
// Purpose: two flip-flop synchroniser for levels entering the system clock domain
// Assumes: each bit is a glitch-free level; bits are synchronised independently
// Notes: only monotonic or slowly changing levels may be grouped on one instance
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] lvl_i,
  input wire logic [WIDTH-1:0] rst_val_i,
  output logic [WIDTH-1:0] lvl_o
);
  // =====================================================================
  // two stage chain
  // =====================================================================
  logic [WIDTH-1:0] meta_r; // first stage, read only by the second
  logic [WIDTH-1:0] sync_r; // second stage, safe to use

  // the reset value is a constant tie at every instance
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= lvl_i ^ rst_val_i;
      sync_r <= meta_r;
    end
  end

  // invert back so that the chain idles at the requested value
  assign lvl_o = sync_r ^ rst_val_i;
endmodule // level_sync

// [rtl/sar_adc_serial_frame_power_ctl.sv]
// Purpose: frame, shift-out, sampler and power control of a serial 12-bit converter
// Assumes: host drives frame and serial clock together; comparator settles per bit
// Notes: link logic runs on the serial clock, mode logic on the system clock
`timescale 1ns/100ps
// What this block does
// - frame fall: hold, convert, drive data
// - sixteen serial clocks complete one frame
// - after edge 13, track at next rise
// - edge 16 releases data output
// - early frame rise aborts, releases output
// - four zeros, then 12 bits msb-first
// - first zero at frame fall, then shifts
// - last bit out on edge 15
// - rise after edge ten keeps power
// - rise between edges two, ten: power-down
// - power-down: output three-state within 35 ns
// - rise before edge two stays normal
// - dummy frame past ten powers up
// - wake frame cut short: back down
// - waking sampler holds until first edge
// - power-on mode undetermined, dummy frame
module sar_adc_serial_frame_power_ctl #(
  parameter logic INIT_POWER_DOWN = 1'b0 // mode after reset; either is legal
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SCLK_I,
  input wire logic FRAME_N_I,
  input wire logic COMP_I,
  output logic SERIAL_RESULT_OUT_O,
  output logic SERIAL_RESULT_OE_O,
  output logic [11:0] DAC_CODE_O,
  output logic HOLD_O,
  output logic POWER_ON_O,
  output logic READY_O
);
  // =====================================================================
  // functions
  // =====================================================================
  // bit position decided on a given falling edge count
  function automatic logic [3:0] bit_pos(input logic [4:0] cnt);
    logic [4:0] diff;
    diff = adc_frame_pkg::EDGE_LSB - cnt;
    return diff[3:0];
  endfunction

  // true while the count lies in the result part of the word
  function automatic logic in_result(input logic [4:0] cnt);
    return (cnt >= adc_frame_pkg::EDGE_MSB) && (cnt <= adc_frame_pkg::EDGE_LSB);
  endfunction

  // one successive approximation step: keep or drop the bit, try the next
  function automatic logic [11:0] sar_step(input logic [11:0] code,
                                           input logic [4:0] cnt,
                                           input logic comp);
    logic [11:0] res;
    logic [3:0] pos;
    res = code;
    pos = bit_pos(cnt);
    if (cnt == adc_frame_pkg::EDGE_TRIAL)
    begin
      res = adc_frame_pkg::CODE_MSB;
    end
    else if (in_result(cnt))
    begin
      res[pos] = comp;
      if (pos != 4'h0)
      begin
        res[pos - 4'h1] = 1'b1;
      end
    end
    return res;
  endfunction

  // =====================================================================
  // reset release
  // =====================================================================
  logic rst_meta_n_r; // first reset stage
  logic rst_n_r; // released reset used by the design

  // assert at once, release after two clean edges
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_meta_n_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_n_r <= 1'b1;
      rst_n_r <= rst_meta_n_r;
    end
  end

  // =====================================================================
  // link side, serial clock domain
  // =====================================================================
  // frame high clears the whole link side, so every frame counts from zero
  // and an early rise throws the running conversion away at once
  wire link_rst_n = rst_n_r & ~FRAME_N_I;

  logic [4:0] cnt_r; // falling edges since frame fall
  logic [11:0] code_r; // trial and result code
  logic dout_r; // serial data bit on the pin
  logic seen1_r; // a falling edge was seen
  logic seen2_r; // second falling edge seen
  logic seen10_r; // tenth falling edge seen
  logic done_r; // sixteenth falling edge seen
  logic rise_seen_r; // a rising edge was seen
  logic track_r; // sampler released on a rising edge

  // counter saturates so that an idle-low frame stays finished
  wire [4:0] cnt_nxt = (cnt_r == adc_frame_pkg::EDGE_LAST) ? cnt_r : cnt_r + 5'h01;
  wire [11:0] code_nxt = sar_step(code_r, cnt_nxt, COMP_I);
  // zeros until the msb edge and on edge 16, comparator decisions from the msb edge to the lsb edge
  wire dout_nxt = in_result(cnt_nxt) & COMP_I;

  // falling edge process: count, decide, shift
  always_ff @(negedge SCLK_I or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      cnt_r <= 5'h00;
      code_r <= adc_frame_pkg::CODE_RESET;
      dout_r <= 1'b0; // first leading zero stands from the frame fall
      seen1_r <= 1'b0;
      seen2_r <= 1'b0;
      seen10_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      dout_r <= dout_nxt;
      seen1_r <= 1'b1;
      seen2_r <= cnt_nxt >= adc_frame_pkg::EDGE_DOWN_MIN;
      seen10_r <= cnt_nxt >= adc_frame_pkg::EDGE_STAY_UP;
      done_r <= cnt_nxt >= adc_frame_pkg::EDGE_LAST;
    end
  end

  // rising edge process: the sampler goes back to track after edge 13
  always_ff @(posedge SCLK_I or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rise_seen_r <= 1'b0;
      track_r <= 1'b0;
    end
    else
    begin
      rise_seen_r <= 1'b1;
      track_r <= cnt_r >= adc_frame_pkg::EDGE_TRACK;
    end
  end

  // every flag is a flop output, or an OR of two, that only rises within a frame, so the
  // grouped crossing can never show a false pattern
  wire [4:0] link_flags = {done_r, track_r, seen10_r, seen2_r, seen1_r | rise_seen_r};

  // =====================================================================
  // crossings into the system clock domain
  // =====================================================================
  logic frame_n_s; // frame after two flops
  logic [4:0] flags_s; // link flags after two flops

  // frame idles high, so its chain resets high
  level_sync #(.WIDTH(1)) u_frame_sync (
    .clk_i(CLK_I),
    .rst_n_i(rst_n_r),
    .lvl_i(FRAME_N_I),
    .rst_val_i(1'b1),
    .lvl_o(frame_n_s)
  );

  // link flags are clear outside a frame
  level_sync #(.WIDTH(adc_frame_pkg::FLG_W)) u_flag_sync (
    .clk_i(CLK_I),
    .rst_n_i(rst_n_r),
    .lvl_i(link_flags),
    .rst_val_i(adc_frame_pkg::FLAGS_CLEAR),
    .lvl_o(flags_s)
  );

  // =====================================================================
  // frame edges and sticky copy of the link flags
  // =====================================================================
  logic frame_low_d_r; // frame low one cycle ago
  logic [4:0] flags_seen_r; // flags gathered during the frame

  wire frame_low = ~frame_n_s;
  wire frame_fall = frame_low & ~frame_low_d_r;
  wire frame_rise = ~frame_low & frame_low_d_r;
  // the link clears its flags when the frame rises; the sticky copy keeps
  // what was reached even if that clear arrives a cycle early
  wire [4:0] flags_dec = flags_seen_r | flags_s;
  wire reached2 = flags_dec[adc_frame_pkg::FLG_SEEN2];
  wire reached10 = flags_dec[adc_frame_pkg::FLG_SEEN10];
  wire [4:0] flags_seen_nxt = frame_fall ? adc_frame_pkg::FLAGS_CLEAR :
                              frame_low ? flags_dec : flags_seen_r;

  // edge history and flag gathering
  always_ff @(posedge CLK_I or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      frame_low_d_r <= 1'b0;
      flags_seen_r <= adc_frame_pkg::FLAGS_CLEAR;
    end
    else
    begin
      frame_low_d_r <= frame_low;
      flags_seen_r <= flags_seen_nxt;
    end
  end

  // =====================================================================
  // power mode
  // =====================================================================
  adc_frame_pkg::power_state_type state_r; // current power mode
  adc_frame_pkg::power_state_type state_nxt; // mode after this cycle

  // mode moves only on frame edges
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      adc_frame_pkg::PWR_NORMAL:
      begin
        // a rise before edge two is a glitch and changes nothing
        if (frame_rise && reached2 && !reached10)
        begin
          state_nxt = adc_frame_pkg::PWR_DOWN;
        end
      end
      adc_frame_pkg::PWR_DOWN:
      begin
        // power-up starts on the frame fall
        if (frame_fall)
        begin
          state_nxt = adc_frame_pkg::PWR_WAKING;
        end
      end
      adc_frame_pkg::PWR_WAKING:
      begin
        // a wake frame must run past edge ten, else it counts as a glitch
        if (frame_rise)
        begin
          state_nxt = reached10 ? adc_frame_pkg::PWR_NORMAL : adc_frame_pkg::PWR_DOWN;
        end
      end
      default:
      begin
        state_nxt = adc_frame_pkg::PWR_NORMAL;
      end
    endcase
  end

  // =====================================================================
  // pin side registers of the system domain
  // =====================================================================
  logic oe_r; // serial data output enable
  logic hold_r; // sampler in hold
  logic power_on_r; // analog section powered
  logic ready_r; // analog section settled
  logic [adc_frame_pkg::PWRUP_CNT_W-1:0] pwr_cnt_r; // time since power-up

  // driven from the frame fall until edge 16 or an early rise
  wire oe_nxt = frame_low & ~flags_s[adc_frame_pkg::FLG_DONE];
  // sampler: hold while down; a wake frame tracks after its first edge;
  // a normal frame holds from its fall until released after edge 13
  wire hold_wake = frame_low & ~flags_s[adc_frame_pkg::FLG_EDGE];
  wire hold_norm = frame_low & ~flags_s[adc_frame_pkg::FLG_TRACK];
  wire hold_nxt = (state_nxt == adc_frame_pkg::PWR_DOWN) ? 1'b1 :
                  (state_nxt == adc_frame_pkg::PWR_WAKING) ? hold_wake : hold_norm;
  wire power_nxt = state_nxt != adc_frame_pkg::PWR_DOWN;
  wire pwr_full = pwr_cnt_r == adc_frame_pkg::PWRUP_CNT_W'(adc_frame_pkg::PWRUP_CYCLES);
  // counts from the wake, saturates, restarts on every power-down
  wire [adc_frame_pkg::PWRUP_CNT_W-1:0] pwr_cnt_nxt = !power_nxt ? '0 :
                                                     pwr_full ? pwr_cnt_r : pwr_cnt_r + 1'b1;

  // the reset mode is a strap-like parameter, so reset values stay constant
  always_ff @(posedge CLK_I or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= INIT_POWER_DOWN ? adc_frame_pkg::PWR_DOWN : adc_frame_pkg::PWR_NORMAL;
      oe_r <= 1'b0;
      hold_r <= INIT_POWER_DOWN;
      power_on_r <= ~INIT_POWER_DOWN;
      ready_r <= 1'b0;
      pwr_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      oe_r <= oe_nxt;
      hold_r <= hold_nxt;
      power_on_r <= power_nxt;
      ready_r <= pwr_full & power_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
    end
  end

  // =====================================================================
  // outputs, each straight from a flop
  // =====================================================================
  assign SERIAL_RESULT_OUT_O = dout_r;
  assign SERIAL_RESULT_OE_O = oe_r;
  assign DAC_CODE_O = code_r;
  assign HOLD_O = hold_r;
  assign POWER_ON_O = power_on_r;
  assign READY_O = ready_r;

  // =====================================================================
  // checks
  // =====================================================================
  a_oe_on_fall: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    frame_fall |=> oe_r)
    else $error("data output not driven after frame fall");

  a_hiz_on_rise: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    frame_rise |=> !oe_r [*2])
    else $error("data output still driven after frame rise");

  a_hiz_after_done: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    $rose(flags_s[adc_frame_pkg::FLG_DONE]) |=> !oe_r && $past(oe_r))
    else $error("data output not released after edge 16");

  a_down_window: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    (frame_rise && state_r == adc_frame_pkg::PWR_NORMAL && reached2 && !reached10)
    |=> state_r == adc_frame_pkg::PWR_DOWN && !power_on_r && !oe_r)
    else $error("power-down not entered");

  a_glitch_normal: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    (frame_rise && state_r == adc_frame_pkg::PWR_NORMAL && !reached2)
    |=> state_r == adc_frame_pkg::PWR_NORMAL && power_on_r)
    else $error("short frame changed the mode");

  a_late_stays_up: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    (frame_rise && state_r == adc_frame_pkg::PWR_NORMAL && reached10)
    |=> state_r == adc_frame_pkg::PWR_NORMAL && !oe_r)
    else $error("late rise left normal mode");

  a_wake_on_fall: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    (frame_fall && state_r == adc_frame_pkg::PWR_DOWN)
    |=> state_r == adc_frame_pkg::PWR_WAKING && power_on_r && hold_r)
    else $error("dummy frame did not start power-up");

  a_wake_abort: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    (frame_rise && state_r == adc_frame_pkg::PWR_WAKING && !reached10)
    |=> state_r == adc_frame_pkg::PWR_DOWN)
    else $error("cut wake frame did not power down");

  a_track_release: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    ($rose(flags_s[adc_frame_pkg::FLG_TRACK]) && frame_low &&
     state_r == adc_frame_pkg::PWR_NORMAL) |=> !hold_r)
    else $error("sampler not back in track after edge 13");

  a_zero_prefix: assert property (@(negedge SCLK_I) disable iff (!link_rst_n)
    (cnt_r < adc_frame_pkg::EDGE_MSB || cnt_r == adc_frame_pkg::EDGE_LAST) |-> !dout_r)
    else $error("leading zero missing");

  a_ready_delay: assert property (@(posedge CLK_I) disable iff (!rst_n_r)
    $rose(power_on_r) |-> !ready_r [*8])
    else $error("ready raised before power-up time");
endmodule // sar_adc_serial_frame_power_ctl

// [verif/adc_host_model.sv]
// Purpose: host serial port model driving frame, serial clock and comparator level
// Assumes: serial clock idles high and stands still between frames
// Notes: data pin level is sampled just before each serial clock fall, and again at each of the first 15 rises
`timescale 1ns/100ps
module adc_host_model (
  input wire logic data_i,
  input wire logic oe_i,
  input wire logic [11:0] dac_i,
  output logic sclk_o,
  output logic frame_n_o,
  output logic comp_o,
  output logic [15:0] word_o,
  output logic [14:0] rise_word_o,
  output logic done_o
);
  // =====================================================================
  // analog stand-in and data pin
  // =====================================================================
  logic [11:0] vin_r; // input level held for this frame
  wire line_w; // level on the shared data pin
  // released pin floats, so a late drive or an early release shows as z
  assign line_w = oe_i ? data_i : 1'bz;
  // straight binary compare against the trial code
  assign comp_o = (vin_r >= dac_i);

  // idle levels at time zero
  initial
  begin
    sclk_o = 1'b1;
    frame_n_o = 1'b1;
    done_o = 1'b0;
    word_o = 16'h0000;
    rise_word_o = 15'h0000;
    vin_r = 12'h000;
  end

  // =====================================================================
  // one frame: fall, a burst of serial clocks, rise
  // =====================================================================
  task automatic run_frame(input int edges, input logic [11:0] vin);
    vin_r = vin;
    frame_n_o = 1'b0;
    #80;
    // the caller picks the burst length, past ten keeps power
    for (int n = 1; n <= edges; n++)
    begin
      word_o = {word_o[14:0], line_w};
      sclk_o = 1'b0;
      #80;
      sclk_o = 1'b1;
      // slow host variant: rise n shows the bit launched by fall n
      if (n <= 15)
        rise_word_o = {rise_word_o[13:0], line_w};
      #80;
    end
    // only a full burst hands over a word
    if (edges >= 16)
    begin
      done_o = 1'b1;
      #1;
      done_o = 1'b0;
    end
    frame_n_o = 1'b1;
    #(adc_frame_pkg::RELEASE_TO_HIZ_DELAY_NS);
  endtask
endmodule // adc_host_model

// [verif/tb_sar_adc_serial_frame_power_ctl.sv]
// Purpose: self-checking bench of the frame, shift-out and power control block
// Assumes: host model makes the 160 ns serial clock, offset from the system clock
// Notes: expected words are queued by the driver and compared by a watcher
`timescale 1ns/100ps
module tb_sar_adc_serial_frame_power_ctl;
  // =====================================================================
  // signals
  // =====================================================================
  logic CLK_I = 1'b0; // system clock
  logic RST_N_I = 1'b0; // reset, held from time zero
  wire sclk_w, frame_n_w, comp_w, done_w; // host side pins
  wire [15:0] word_w; // word captured by the host
  wire [14:0] rise_w; // word captured on rising edges
  logic [15:0] exp_w; // note taken off the queue
  logic SERIAL_RESULT_OUT_O, SERIAL_RESULT_OE_O, HOLD_O, POWER_ON_O, READY_O;
  logic [11:0] DAC_CODE_O; // trial code to the comparator
  logic [15:0] exp_q[$]; // expected words, oldest first
  logic [11:0] vin; // level for the next frame
  int seed = 32'h40a5b897; // fixed seed
  int err_count = 0;
  int num_checks = 0;

  // 200 MHz system clock
  always #2.5 CLK_I = ~CLK_I;

  sar_adc_serial_frame_power_ctl #(.INIT_POWER_DOWN(1'b0)) DUT (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .SCLK_I(sclk_w),
    .FRAME_N_I(frame_n_w),
    .COMP_I(comp_w),
    .SERIAL_RESULT_OUT_O(SERIAL_RESULT_OUT_O),
    .SERIAL_RESULT_OE_O(SERIAL_RESULT_OE_O),
    .DAC_CODE_O(DAC_CODE_O),
    .HOLD_O(HOLD_O),
    .POWER_ON_O(POWER_ON_O),
    .READY_O(READY_O)
  );

  adc_host_model HOST (
    .data_i(SERIAL_RESULT_OUT_O),
    .oe_i(SERIAL_RESULT_OE_O),
    .dac_i(DAC_CODE_O),
    .sclk_o(sclk_w),
    .frame_n_o(frame_n_w),
    .comp_o(comp_w),
    .word_o(word_w),
    .rise_word_o(rise_w),
    .done_o(done_w)
  );

  // =====================================================================
  // compare and verdict
  // =====================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watcher: each finished word is held against the oldest note
  always @(posedge done_w)
  begin
    exp_w = exp_q.pop_front();
    check(word_w, exp_w);
    // rising-edge capture misses the first zero only
    check(16'(rise_w), 16'(exp_w[14:0]));
  end

  // one frame with checks early in it and just after the rise
  task automatic frame(input int edges, input logic [11:0] v, input logic hold_mid);
    @(negedge CLK_I);
    #1.3;
    if (edges >= 16)
      exp_q.push_back({4'h0, v});
    fork
      HOST.run_frame(edges, v);
      begin
        #30;
        check(16'(SERIAL_RESULT_OE_O), 16'h0001);
        #170;
        // waking sampler tracks after the first edge, normal one holds
        check(16'(HOLD_O), 16'(hold_mid));
        // a normal frame finds the section settled, a wake frame not yet
        check(16'(READY_O), 16'(hold_mid));
      end
    join
    check(16'(SERIAL_RESULT_OE_O), 16'h0000);
    #400;
  endtask

  // =====================================================================
  // main sequence
  // =====================================================================
  initial
  begin
    repeat (2) @(posedge CLK_I);
    @(negedge CLK_I);
    RST_N_I <= 1'b1;
    #1;
    check(16'(SERIAL_RESULT_OE_O), 16'h0000);
    check(16'(POWER_ON_O), 16'h0001);
    repeat (300) @(negedge CLK_I);
    check(16'(READY_O), 16'h0001);
    // boundary codes first, then random levels
    for (int i = 0; i < 6; i++)
    begin
      vin = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
      frame(16, vin, 1'b1);
      check(16'(HOLD_O), 16'h0000);
      check(16'(POWER_ON_O), 16'h0001);
    end
    frame(12, 12'($random(seed)), 1'b1);
    check(16'(POWER_ON_O), 16'h0001);
    frame(1, 12'($random(seed)), 1'b1);
    check(16'(POWER_ON_O), 16'h0001);
    frame(5, 12'($random(seed)), 1'b1);
    check(16'(POWER_ON_O), 16'h0000);
    check(16'(READY_O), 16'h0000);
    // wake frame cut short
    frame(4, 12'($random(seed)), 1'b0);
    check(16'(POWER_ON_O), 16'h0000);
    // dummy frame past ten wakes the analog section
    frame(10, 12'($random(seed)), 1'b0);
    check(16'(POWER_ON_O), 16'h0001);
    repeat (220) @(negedge CLK_I);
    check(16'(READY_O), 16'h0001);
    frame(16, 12'($random(seed)), 1'b1);
    summarize();
  end

  // watchdog, well past the run of about thirty-two microseconds
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
endmodule // tb_sar_adc_serial_frame_power_ctl
